// ### shared/trace_mon_cfg.svh
// Constants for the trace identifier mismatch monitor.
// Assumes a single 50 MHz clock domain and a plain register port.
// Function
// - Section trace differs: raise section alarm
// - Path trace differs: raise path alarm
// - Path alarm only in manual mode
// - Manual mode compares software-written expected string
// - Auto mode learns expected from received string
// - Section mismatch may insert AIS-L, RFI-L
// - Per-port control disables AIS-L/RFI-L actions
// - Transparent: pass overhead, monitor-level section alarm
// - Path alarm severity: termination SA, monitor NSA
`ifndef TRACE_MON_CFG_SVH
`define TRACE_MON_CFG_SVH
// ==========================================
// Register offsets (word index = byte address / 4)
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_SEC_EXP_BASE 8'h40
`define REG_PATH_EXP_BASE 8'h80
`define REG_SEC_RX_BASE 8'hC0
// ==========================================
// Control fields
`define CTRL_SEC_MODE_LSB 0
`define CTRL_PATH_MODE_LSB 2
`define CTRL_CONSEQ_DIS_BIT 4
`define CTRL_TRANSPARENT_BIT 5
`define CTRL_PATH_TERM_BIT 6
`define CTRL_RESET_VAL 32'h0000_0000
// ==========================================
// Sizes
`define TRACE_LEN 16
`endif

// ### shared/trace_mon_pkg.sv
// Types for the trace identifier mismatch monitor.
// Assumes trace_mon_cfg.svh supplies the numeric constants.
package trace_mon_pkg;
   // ==========================================
   // Trace mode
   typedef enum logic [1:0]
   {
      MODE_OFF = 2'b00,
      MODE_MANUAL = 2'b01,
      MODE_AUTO = 2'b11
   } trace_mode_t;
   // ==========================================
   // Receive overhead byte strobe group
   typedef struct packed
   {
      logic valid;
      logic [7:0] data;
   } oh_byte_t;
   // Alarm outputs
   typedef struct packed
   {
      logic sec_tim;
      logic mon_tim;
      logic path_tim;
      logic path_sa;
      logic ais_l;
      logic rfi_l;
   } alarm_t;
endpackage

// ### design/trace_store.sv
// Small trace string memory, one byte per position, registered read.
// Assumes one write port and one read port on the same clock.
`timescale 1ns/100ps
`default_nettype none
module trace_store
#(
   parameter int DEPTH = 16
)
(
   input wire logic sys_clk_in,
   input wire logic wr_en_in,
   input wire logic [$clog2(DEPTH)-1:0] wr_addr_in,
   input wire logic [7:0] wr_data_in,
   input wire logic [$clog2(DEPTH)-1:0] rd_addr_in,
   output logic [7:0] rd_data_out
);
   // Storage array
   logic [7:0] mem_ff [DEPTH];
   // ==========================================
   // Write port, no reset so it maps to RAM
   always_ff @(posedge sys_clk_in)
   begin
      if (wr_en_in)
      begin
         mem_ff[wr_addr_in] <= wr_data_in;
      end
   end
   // Registered read port
   always_ff @(posedge sys_clk_in)
   begin
      rd_data_out <= mem_ff[rd_addr_in];
   end
endmodule
`default_nettype wire

// ### design/trace_identifier_mismatch_monitor.sv
// Trace mismatch monitor: compares received section and path trace
// strings with expected strings, raises alarms and consequent actions.
// Assumes overhead byte strobes come from logic on sys_clk_in, each
// carrying its byte position; string check ends at position LEN-1.
//
// The strobed register port and the register addresses were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "trace_mon_cfg.svh"
module trace_identifier_mismatch_monitor
#(
   parameter int LEN = `TRACE_LEN
)
(
   input wire logic sys_clk_in,
   input wire logic rst_in,
   input wire logic [7:0] addr_in,
   input wire logic [31:0] wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   output logic [31:0] rdata_out,
   input wire trace_mon_pkg::oh_byte_t sec_rx_in,
   input wire logic [$clog2(LEN)-1:0] sec_pos_in,
   input wire trace_mon_pkg::oh_byte_t path_rx_in,
   input wire logic [$clog2(LEN)-1:0] path_pos_in,
   input wire logic [7:0] oh_thru_in,
   output logic [7:0] oh_thru_out,
   output trace_mon_pkg::alarm_t alarm_out
);
   localparam int AW = $clog2(LEN);
   // ==========================================
   // Control register
   logic [31:0] ctrl_ff;
   // Per-string running mismatch flags
   logic sec_diff_ff;
   logic path_diff_ff;
   // Alarm register
   trace_mon_pkg::alarm_t alarm_ff;
   // Pass-through register
   logic [7:0] thru_ff;
   // Expected string memories
   logic [7:0] sec_exp [LEN];
   logic [7:0] path_exp [LEN];
   // Received section string comes back from the store below
   logic [7:0] mem_rd;
   logic [AW-1:0] rd_idx;
   logic rd_mem_sel_ff;
   trace_mon_pkg::trace_mode_t sec_mode;
   trace_mon_pkg::trace_mode_t path_mode;
   logic sec_hit;
   logic path_hit;
   logic sec_last;
   logic path_last;
   // Decoded modes
   assign sec_mode = trace_mon_pkg::trace_mode_t'(ctrl_ff[`CTRL_SEC_MODE_LSB +: 2]);
   assign path_mode = trace_mon_pkg::trace_mode_t'(ctrl_ff[`CTRL_PATH_MODE_LSB +: 2]);
   // ==========================================
   // Window decode of a string address
   function automatic logic in_window(input logic [7:0] a, input logic [7:0] base);
      // Nine bits: the top window ends at 0x100, which eight bits would wrap
      in_window = (a >= base) && ({1'b0, a} < ({1'b0, base} + 9'(LEN * 4)));
   endfunction
   // Compare a received byte with the expected one
   function automatic logic byte_miss(input logic [7:0] rx, input logic [7:0] ex);
      byte_miss = (rx != ex);
   endfunction
   assign rd_idx = addr_in[AW+1:2];
   // ==========================================
   // Control register writes
   always_ff @(posedge sys_clk_in)
   begin
      if (rst_in)
      begin
         ctrl_ff <= `CTRL_RESET_VAL;
      end
      else if (wr_in && addr_in == `REG_CTRL)
      begin
         ctrl_ff <= {25'h000_0000, wdata_in[6:0]};
      end
   end
   // ==========================================
   // Expected strings: software in manual, learned in auto
   always_ff @(posedge sys_clk_in)
   begin
      // Learning wins over a software write in the same cycle
      if (sec_rx_in.valid && sec_mode == trace_mon_pkg::MODE_AUTO)
      begin
         sec_exp[sec_pos_in] <= sec_rx_in.data;
      end
      else if (wr_in && in_window(addr_in, `REG_SEC_EXP_BASE))
      begin
         sec_exp[rd_idx] <= wdata_in[7:0];
      end
      // Path string, same arrangement
      if (path_rx_in.valid && path_mode == trace_mon_pkg::MODE_AUTO)
      begin
         path_exp[path_pos_in] <= path_rx_in.data;
      end
      else if (wr_in && in_window(addr_in, `REG_PATH_EXP_BASE))
      begin
         path_exp[rd_idx] <= wdata_in[7:0];
      end
   end
   // ==========================================
   // Byte comparisons; auto mode matches by construction
   assign sec_hit = sec_rx_in.valid && sec_mode != trace_mon_pkg::MODE_AUTO &&
                    byte_miss(sec_rx_in.data, sec_exp[sec_pos_in]);
   assign path_hit = path_rx_in.valid && path_mode == trace_mon_pkg::MODE_MANUAL &&
                     byte_miss(path_rx_in.data, path_exp[path_pos_in]);
   assign sec_last = sec_rx_in.valid && sec_pos_in == AW'(LEN - 1);
   assign path_last = path_rx_in.valid && path_pos_in == AW'(LEN - 1);
   // Accumulate mismatch across one string
   always_ff @(posedge sys_clk_in)
   begin
      if (rst_in)
      begin
         sec_diff_ff <= 1'b0;
         path_diff_ff <= 1'b0;
      end
      else
      begin
         if (sec_last)
            sec_diff_ff <= 1'b0;
         else if (sec_hit)
            sec_diff_ff <= 1'b1;
         if (path_last)
            path_diff_ff <= 1'b0;
         else if (path_hit)
            path_diff_ff <= 1'b1;
      end
   end
   // ==========================================
   // Trace alarms updated at the end of each full string; severity and actions every cycle
   always_ff @(posedge sys_clk_in)
   begin
      if (rst_in)
      begin
         alarm_ff <= '0;
      end
      else
      begin
         // Mode off clears at once, not at the next string end
         if (sec_mode == trace_mon_pkg::MODE_OFF)
         begin
            alarm_ff.sec_tim <= 1'b0;
            alarm_ff.mon_tim <= 1'b0;
         end
         else if (sec_last)
         begin
            // Transparent ports report the monitor alarm only
            alarm_ff.sec_tim <= (sec_diff_ff || sec_hit) &&
                                !ctrl_ff[`CTRL_TRANSPARENT_BIT];
            alarm_ff.mon_tim <= (sec_diff_ff || sec_hit) &&
                                ctrl_ff[`CTRL_TRANSPARENT_BIT];
         end
         // No path check, no path alarm
         if (path_mode == trace_mon_pkg::MODE_OFF)
         begin
            alarm_ff.path_tim <= 1'b0;
         end
         else if (path_last)
         begin
            alarm_ff.path_tim <= path_diff_ff || path_hit;
         end
         // Severity follows point type
         alarm_ff.path_sa <= ctrl_ff[`CTRL_PATH_TERM_BIT];
         // Consequent actions track the section alarm
         alarm_ff.ais_l <= alarm_ff.sec_tim && !ctrl_ff[`CTRL_CONSEQ_DIS_BIT];
         alarm_ff.rfi_l <= alarm_ff.sec_tim && !ctrl_ff[`CTRL_CONSEQ_DIS_BIT];
      end
   end
   // ==========================================
   // Overhead pass-through, never altered
   always_ff @(posedge sys_clk_in)
   begin
      if (rst_in)
         thru_ff <= 8'h00;
      else
         thru_ff <= oh_thru_in;
   end
   // ==========================================
   // Received string readback memory
   // Only the section string is kept; the path string is not readable
   trace_store #(.DEPTH(LEN)) u_rx_store
   (
      .sys_clk_in(sys_clk_in),
      .wr_en_in(sec_rx_in.valid),
      .wr_addr_in(sec_pos_in),
      .wr_data_in(sec_rx_in.data),
      .rd_addr_in(rd_idx),
      .rd_data_out(mem_rd)
   );
   // Remember whether a read hit the received window
   always_ff @(posedge sys_clk_in)
   begin
      if (rst_in)
         rd_mem_sel_ff <= 1'b0;
      else
         rd_mem_sel_ff <= rd_in && in_window(addr_in, `REG_SEC_RX_BASE);
   end
   // ==========================================
   // Read data, one cycle after the strobe; unmapped reads zero
   logic [31:0] rdata_ff;
   always_ff @(posedge sys_clk_in)
   begin
      if (rst_in || !rd_in)
         rdata_ff <= 32'h0000_0000;
      else if (addr_in == `REG_CTRL)
         rdata_ff <= ctrl_ff;
      else if (addr_in == `REG_STATUS)
         rdata_ff <= {26'h000_0000, alarm_ff};
      else if (in_window(addr_in, `REG_SEC_EXP_BASE))
         rdata_ff <= {24'h00_0000, sec_exp[rd_idx]};
      else if (in_window(addr_in, `REG_PATH_EXP_BASE))
         rdata_ff <= {24'h00_0000, path_exp[rd_idx]};
      // Received window and unmapped offsets read zero here
      else
         rdata_ff <= 32'h0000_0000;
   end
   assign rdata_out = rd_mem_sel_ff ? {24'h00_0000, mem_rd} : rdata_ff;
   assign alarm_out = alarm_ff;
   assign oh_thru_out = thru_ff;
endmodule
`default_nettype wire

// ### tb/trace_tx_model.sv
// Far-end transmitter model: sends one 16-byte trace string per request.
// Assumes the monitor takes each byte on the edge where valid is high.
`timescale 1ns/100ps
`default_nettype none
module trace_tx_model
(
   input wire logic sys_clk_in,
   input wire logic rst_in,
   input wire logic go_in,
   input wire logic [127:0] str_in,
   output trace_mon_pkg::oh_byte_t byte_out,
   output logic [3:0] pos_out,
   output logic busy_out
);
   // ==========================================
   // Byte sequencer
   // Idle data is inverted each cycle so no stale byte looks valid
   always_ff @(posedge sys_clk_in)
      if (rst_in)
      begin
         busy_out <= 1'b0;
         pos_out <= 4'h0;
         byte_out <= '0;
      end
      else if (busy_out && pos_out != 4'hf)
      begin
         pos_out <= pos_out + 4'h1;
         byte_out <= {1'b1, str_in[8 * (pos_out + 4'h1) +: 8]};
      end
      else
      begin
         busy_out <= go_in;
         pos_out <= 4'h0;
         byte_out <= go_in ? {1'b1, str_in[7:0]} : {1'b0, ~byte_out.data};
      end
endmodule
`default_nettype wire

// ### tb/trace_mon_props.sv
// Port-level checks on the trace mismatch monitor.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/100ps
`default_nettype none
module trace_mon_props
#(
   parameter int LEN = 16
)
(
   input wire logic sys_clk_in,
   input wire logic rst_in,
   input wire logic wr_in,
   input wire trace_mon_pkg::oh_byte_t sec_rx_in,
   input wire logic [$clog2(LEN)-1:0] sec_pos_in,
   input wire trace_mon_pkg::oh_byte_t path_rx_in,
   input wire logic [$clog2(LEN)-1:0] path_pos_in,
   input wire logic [7:0] oh_thru_in,
   input wire logic [7:0] oh_thru_out,
   input wire trace_mon_pkg::alarm_t alarm_out
);
   // ==========================================
   // Alarm timing
   default clocking cb @(posedge sys_clk_in);
   endclocking
   default disable iff (rst_in);
   // Trace alarms move only at a string end or after a control write
   wire logic sec_end = sec_rx_in.valid && sec_pos_in == LEN - 1;
   wire logic path_end = path_rx_in.valid && path_pos_in == LEN - 1;
   property p_thru;
      !$past(rst_in) |-> oh_thru_out == $past(oh_thru_in);
   endproperty
   a_thru: assert property (p_thru) else $error("overhead byte altered");
   property p_ais;
      alarm_out.ais_l |-> $past(alarm_out.sec_tim);
   endproperty
   a_ais: assert property (p_ais) else $error("ais without section alarm");
   property p_pair;
      alarm_out.rfi_l == alarm_out.ais_l;
   endproperty
   a_pair: assert property (p_pair) else $error("rfi and ais differ");
   property p_clr;
      $fell(alarm_out.sec_tim) |=> !alarm_out.ais_l;
   endproperty
   a_clr: assert property (p_clr) else $error("ais kept after clear");
   property p_excl;
      !(alarm_out.sec_tim && alarm_out.mon_tim);
   endproperty
   a_excl: assert property (p_excl) else $error("both section alarms");
   property p_sec;
      $changed(alarm_out.sec_tim) |-> $past(sec_end) || $past(wr_in) || $past(wr_in, 2);
   endproperty
   a_sec: assert property (p_sec) else $error("section alarm moved early");
   property p_mon;
      $changed(alarm_out.mon_tim) |-> $past(sec_end) || $past(wr_in) || $past(wr_in, 2);
   endproperty
   a_mon: assert property (p_mon) else $error("monitor alarm moved early");
   property p_path;
      $changed(alarm_out.path_tim) |-> $past(path_end) || $past(wr_in) || $past(wr_in, 2);
   endproperty
   a_path: assert property (p_path) else $error("path alarm moved early");
   c_sec: cover property (alarm_out.ais_l);
   c_mon: cover property (alarm_out.mon_tim);
   c_path: cover property (alarm_out.path_tim && alarm_out.path_sa);
endmodule
bind trace_identifier_mismatch_monitor trace_mon_props #(.LEN(LEN)) u_trace_mon_props
(.sys_clk_in(sys_clk_in), .rst_in(rst_in), .wr_in(wr_in), .sec_rx_in(sec_rx_in),
 .sec_pos_in(sec_pos_in), .path_rx_in(path_rx_in), .path_pos_in(path_pos_in),
 .oh_thru_in(oh_thru_in), .oh_thru_out(oh_thru_out), .alarm_out(alarm_out));
`default_nettype wire

// ### tb/trace_identifier_mismatch_monitor_tb_top.sv
// Self-checking bench for the trace mismatch monitor.
// Assumes two transmitter models feed the section and path lanes.
`timescale 1ns/100ps
`default_nettype none
`include "trace_mon_cfg.svh"
module trace_identifier_mismatch_monitor_tb_top;
   typedef struct packed
   {
      logic [7:0] ctrl;
      logic sbad;
      logic pbad;
      logic [5:0] al;
   } row_t;
   // Bad string differs only in the last byte, the latest place to notice
   localparam logic [127:0] SA = 128'h0f0e_0d0c_0b0a_0908_0706_0504_0302_0100;
   localparam logic [127:0] SB = SA ^ {8'h01, 120'h0};
   logic sys_clk_in = 1'b0;
   logic rst_in = 1'b1;
   logic [7:0] addr = 8'h00;
   logic [31:0] wdata = 32'h0000_0000;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic go = 1'b0;
   logic [7:0] thru = 8'h00;
   logic [127:0] sstr = SA;
   logic [127:0] pstr = SA;
   logic [31:0] rdata;
   logic [7:0] thru_q;
   logic sbusy;
   logic pbusy;
   logic [3:0] spos;
   logic [3:0] ppos;
   trace_mon_pkg::oh_byte_t sbyte;
   trace_mon_pkg::oh_byte_t pbyte;
   trace_mon_pkg::alarm_t alarm;
   int errors = 0;
   int cmp_count = 0;
   // Control, lanes sending the bad string, expected alarm bits
   row_t rows [8] = '{'{8'h05, 1'b0, 1'b0, 6'h00}, '{8'h05, 1'b1, 1'b0, 6'h23},
      '{8'h05, 1'b0, 1'b0, 6'h00}, '{8'h05, 1'b0, 1'b1, 6'h08}, '{8'h45, 1'b0, 1'b1, 6'h0c},
      '{8'h15, 1'b1, 1'b0, 6'h20}, '{8'h25, 1'b1, 1'b0, 6'h10}, '{8'h01, 1'b0, 1'b1, 6'h00}};
   always #10 sys_clk_in = ~sys_clk_in;
   trace_identifier_mismatch_monitor u_trace_identifier_mismatch_monitor
   (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .addr_in(addr), .wdata_in(wdata), .wr_in(wr),
    .rd_in(rd), .rdata_out(rdata), .sec_rx_in(sbyte), .sec_pos_in(spos), .path_rx_in(pbyte),
    .path_pos_in(ppos), .oh_thru_in(thru), .oh_thru_out(thru_q), .alarm_out(alarm));
   trace_tx_model u_trace_tx_model
   (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .go_in(go), .str_in(sstr), .byte_out(sbyte),
    .pos_out(spos), .busy_out(sbusy));
   trace_tx_model u_trace_tx_model_path
   (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .go_in(go), .str_in(pstr), .byte_out(pbyte),
    .pos_out(ppos), .busy_out(pbusy));
   // ==========================================
   // Shared tasks
   task end_of_test;
      $display("comparisons %0d mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         errors++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task wr_reg(input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk_in);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge sys_clk_in);
      wr <= 1'b0;
   endtask
   // Read data stands only in the cycle after the strobe
   task rd_reg(input logic [7:0] a, output logic [31:0] d);
      @(posedge sys_clk_in);
      addr <= a;
      rd <= 1'b1;
      @(posedge sys_clk_in);
      rd <= 1'b0;
      #1 d = rdata;
   endtask
   task load(input logic [7:0] base, input logic [127:0] s);
      for (int i = 0; i < 16; i++)
         wr_reg(base + 8'(4 * i), {24'h00_0000, s[8 * i +: 8]});
   endtask
   // Both lanes send together; bounded wait, then the fixed alarm latency
   task send(input logic [127:0] s, input logic [127:0] p);
      int n;
      @(posedge sys_clk_in);
      sstr <= s;
      pstr <= p;
      go <= 1'b1;
      @(posedge sys_clk_in);
      go <= 1'b0;
      #1;
      for (n = 0; n < 40 && (sbusy || pbusy); n++)
         @(posedge sys_clk_in);
      if (n == 40)
      begin
         errors++;
         end_of_test;
      end
      repeat (3) @(posedge sys_clk_in);
      #1;
   endtask
   // ==========================================
   // Main sequence
   initial
   begin
      logic [31:0] v;
      repeat (2) @(posedge sys_clk_in);
      rst_in <= 1'b0;
      rd_reg(`REG_CTRL, v);
      chk("ctrl_reset", v, `CTRL_RESET_VAL);
      chk("alarm_reset", {26'h0, alarm}, 32'h0000_0000);
      rd_reg(8'h3c, v);
      chk("unmapped", v, 32'h0000_0000);
      @(posedge sys_clk_in);
      thru <= 8'ha5;
      @(posedge sys_clk_in);
      #1 chk("thru", {24'h00_0000, thru_q}, 32'h0000_00a5);
      $display("reset and pass-through test done");
      load(`REG_SEC_EXP_BASE, SA);
      load(`REG_PATH_EXP_BASE, SA);
      foreach (rows[i])
      begin
         wr_reg(`REG_CTRL, {24'h00_0000, rows[i].ctrl});
         send(rows[i].sbad ? SB : SA, rows[i].pbad ? SB : SA);
         chk("alarm", {26'h0, alarm}, {26'h0, rows[i].al});
         rd_reg(`REG_STATUS, v);
         chk("status", v, {26'h0, rows[i].al});
         $display("row %0d done", i);
      end
      wr_reg(`REG_CTRL, 32'h0000_000f);
      send(SB, SB);
      chk("alarm_auto", {26'h0, alarm}, 32'h0000_0000);
      rd_reg(`REG_SEC_EXP_BASE + 8'h3c, v);
      chk("learned", v, 32'h0000_000e);
      rd_reg(`REG_SEC_RX_BASE + 8'h3c, v);
      chk("rx_last", v, 32'h0000_000e);
      $display("auto learn test done");
      // Learned strings now hold SB, so SA mismatches on both lanes
      wr_reg(`REG_CTRL, 32'h0000_0005);
      send(SA, SA);
      chk("alarm_both", {26'h0, alarm}, 32'h0000_002b);
      // Turning the checks off must clear the alarms without a string end
      wr_reg(`REG_CTRL, 32'h0000_0000);
      repeat (2) @(posedge sys_clk_in);
      #1 chk("alarm_off", {26'h0, alarm}, 32'h0000_0000);
      $display("checks off test done");
      // Reset in mid-run with alarms raised
      wr_reg(`REG_CTRL, 32'h0000_0005);
      send(SA, SA);
      chk("alarm_pre_rst", {26'h0, alarm}, 32'h0000_002b);
      @(posedge sys_clk_in);
      rst_in <= 1'b1;
      repeat (2) @(posedge sys_clk_in);
      rst_in <= 1'b0;
      @(posedge sys_clk_in);
      #1 chk("alarm_rst", {26'h0, alarm}, 32'h0000_0000);
      rd_reg(`REG_CTRL, v);
      chk("ctrl_rst", v, `CTRL_RESET_VAL);
      $display("mid-run reset test done");
      end_of_test;
   end
endmodule
`default_nettype wire
